// file: src/cantx_regs.vh
// register offsets, field positions and counts of the transmit buffer set
`ifndef CANTX_REGS_VH
`define CANTX_REGS_VH

// apb address decode: byte address = {region, word, 2'b00}
`define CANTX_ADDR_W 12
`define CANTX_BUF_STRIDE 12'h040
`define CANTX_NUM_BUF 3
`define CANTX_NUM_BYTES 8

// word index inside one buffer region (byte offset / 4)
`define CANTX_W_CONTROL 4'h0
`define CANTX_W_IDENT_HIGH 4'h1
`define CANTX_W_IDENT_LOW 4'h2
`define CANTX_W_EXT_HIGH 4'h3
`define CANTX_W_EXT_LOW 4'h4
`define CANTX_W_LENGTH 4'h5
`define CANTX_W_PAYLOAD0 4'h8

// common region holding the counter and the error status
`define CANTX_REGION_COMMON 2'h3
`define CANTX_W_ERR_COUNT 4'h0
`define CANTX_W_ERR_STATUS 4'h1

// tx_buffer_control fields
`define CANTX_CON_ABORTED 6
`define CANTX_CON_ARB_LOST 5
`define CANTX_CON_BUS_ERR 4
`define CANTX_CON_REQUEST 3
`define CANTX_CON_PRI_MSB 1

// tx_ident_low fields
`define CANTX_IDL_EXT_SEL 3

// tx_length_code fields
`define CANTX_LEN_REMOTE 6

// error status fields
`define CANTX_ST_BUS_OFF 5
`define CANTX_ST_PASSIVE 4

// error counting
`define CANTX_TEC_W 9
`define CANTX_TEC_ERR_STEP 9'h008
`define CANTX_TEC_PASSIVE 9'h07F
`define CANTX_TEC_BUS_OFF 9'h0FF
`define CANTX_TEC_MAX 9'h1FF
`define CANTX_RECOVERY_RUNS 7'h7F

`define CANTX_RESET_BYTE 8'h00
`endif

// file: src/cantx_buffer_set.v
// transmit buffer set: apb registers, buffer arbitration, error counter
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "cantx_regs.vh"

module cantx_buffer_set (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [`CANTX_ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_tx_done,
  input wire i_tx_arb_lost,
  input wire i_tx_bus_err,
  input wire i_recessive_run,
  output reg o_tx_start,
  output reg o_tx_busy,
  output reg [28:0] o_tx_ident,
  output reg o_tx_extended,
  output reg o_tx_remote,
  output reg [3:0] o_tx_length,
  output reg [63:0] o_tx_payload,
  output reg o_bus_off_flag,
  output reg o_send_passive_flag
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;

  // word index decode shared by the read mux and the write path
  function is_payload;
    input [3:0] word;
    begin
      is_payload = word[3];
    end
  endfunction

  // priority compare: higher code wins, ties keep the earlier index
  function beats;
    input [1:0] pri_new;
    input [1:0] pri_old;
    input have_old;
    begin
      beats = !have_old || (pri_new > pri_old);
    end
  endfunction

  // per-buffer control state, then the sequencer state and current buffer index
  reg [2:0] req_reg;
  reg [2:0] abt_reg;
  reg [2:0] larb_reg;
  reg [2:0] berr_reg;
  reg [2:0] abt_pend_reg;
  reg [5:0] pri_reg;
  reg [1:0] state_reg;
  reg [1:0] cur_reg;

  // per-buffer frame storage, all flip-flops
  reg [7:0] idh_reg [0:2];
  reg [7:0] idl_reg [0:2];
  reg [7:0] eidh_reg [0:2];
  reg [7:0] eidl_reg [0:2];
  reg [7:0] len_reg [0:2];
  reg [7:0] pay_reg [0:23];

  // error counting
  reg [`CANTX_TEC_W-1:0] tec_reg;
  reg [`CANTX_TEC_W-1:0] tec_next;
  reg [6:0] run_cnt_reg;

  // bus decode
  wire [1:0] region;
  wire [3:0] word;
  wire addr_hi_ok;
  wire access;
  wire wr_go;
  wire rd_go;
  wire cur_done;
  wire cur_fail;

  assign region = i_paddr[7:6];
  assign word = i_paddr[5:2];
  assign addr_hi_ok = (i_paddr[`CANTX_ADDR_W-1:8] == 4'h0) &&
                      (i_paddr[1:0] == 2'h0);
  // the first access cycle raises pready, the second completes the transfer
  assign access = i_psel && i_penable && !o_pready;
  assign wr_go = i_psel && i_penable && o_pready && i_pwrite;
  assign rd_go = access && !i_pwrite;
  assign cur_done = (state_reg == ST_SEND) && i_tx_done;
  assign cur_fail = (state_reg == ST_SEND) && !i_tx_done &&
                    (i_tx_arb_lost || i_tx_bus_err);

  // read data and decode error, latched on the same edge that raises pready
  reg [31:0] rd_next;
  reg hit_next;
  always @* begin
    rd_next = 32'h0000_0000;
    hit_next = 1'b0;
    if (addr_hi_ok && region == `CANTX_REGION_COMMON) begin
      case (word)
        `CANTX_W_ERR_COUNT: begin
          hit_next = 1'b1;
          // saturate while bus-off so the low byte never looks healthy
          rd_next[7:0] = tec_reg[8] ? 8'hFF : tec_reg[7:0];
        end
        `CANTX_W_ERR_STATUS: begin
          hit_next = 1'b1;
          rd_next[`CANTX_ST_BUS_OFF] = o_bus_off_flag;
          rd_next[`CANTX_ST_PASSIVE] = o_send_passive_flag;
        end
        default: hit_next = 1'b0;
      endcase
    end else if (addr_hi_ok) begin
      if (is_payload(word)) begin
        hit_next = 1'b1;
        rd_next[7:0] = pay_reg[region * 8 + word[2:0]];
      end else begin
        case (word)
          `CANTX_W_CONTROL: begin
            hit_next = 1'b1;
            // bits 7 and 2 stay zero
            rd_next[7:0] = {1'b0, abt_reg[region], larb_reg[region],
                            berr_reg[region], req_reg[region], 1'b0,
                            pri_reg[region*2 +: 2]};
          end
          `CANTX_W_IDENT_HIGH: begin
            hit_next = 1'b1;
            rd_next[7:0] = idh_reg[region];
          end
          `CANTX_W_IDENT_LOW: begin
            hit_next = 1'b1;
            rd_next[7:0] = idl_reg[region] & 8'hEB;
          end
          `CANTX_W_EXT_HIGH: begin
            hit_next = 1'b1;
            rd_next[7:0] = eidh_reg[region];
          end
          `CANTX_W_EXT_LOW: begin
            hit_next = 1'b1;
            rd_next[7:0] = eidl_reg[region];
          end
          `CANTX_W_LENGTH: begin
            hit_next = 1'b1;
            rd_next[7:0] = len_reg[region] & 8'h4F;
          end
          default: hit_next = 1'b0;
        endcase
      end
    end
  end

  // apb answer: one wait state, error on unmapped addresses
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= access;
      o_pslverr <= access && !hit_next;
      if (rd_go) begin
        o_prdata <= rd_next;
      end
    end
  end

  // per-buffer request and status flags; hardware events come last
  // so that a flag set by the engine wins over a clear in the same cycle
  genvar gb;
  generate
    for (gb = 0; gb < `CANTX_NUM_BUF; gb = gb + 1) begin : g_buf
      wire sel_con;
      wire set_req;
      wire is_cur;
      assign sel_con = wr_go && addr_hi_ok && region == gb &&
                       word == `CANTX_W_CONTROL;
      assign set_req = sel_con && i_pwdata[`CANTX_CON_REQUEST];
      assign is_cur = (state_reg == ST_SEND) && (cur_reg == gb);
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          req_reg[gb] <= 1'b0;
          abt_reg[gb] <= 1'b0;
          larb_reg[gb] <= 1'b0;
          berr_reg[gb] <= 1'b0;
          abt_pend_reg[gb] <= 1'b0;
          pri_reg[gb*2 +: 2] <= 2'b00;
        end else begin
          if (sel_con) begin
            pri_reg[gb*2 +: 2] <= i_pwdata[`CANTX_CON_PRI_MSB:0];
          end
          if (set_req) begin
            req_reg[gb] <= 1'b1;
            abt_reg[gb] <= 1'b0;
            larb_reg[gb] <= 1'b0;
            berr_reg[gb] <= 1'b0;
            abt_pend_reg[gb] <= 1'b0;
          end else if (sel_con && req_reg[gb]) begin
            // a frame on the wire cannot be cut; abort it only if this try fails
            if (is_cur) begin
              abt_pend_reg[gb] <= 1'b1;
            end else begin
              req_reg[gb] <= 1'b0;
              abt_reg[gb] <= 1'b1;
            end
          end
          if (is_cur && i_tx_done && !set_req) begin
            req_reg[gb] <= 1'b0;
            abt_pend_reg[gb] <= 1'b0;
          end else if (is_cur && (cur_fail)) begin
            if (i_tx_arb_lost) begin
              larb_reg[gb] <= 1'b1;
            end
            if (i_tx_bus_err) begin
              berr_reg[gb] <= 1'b1;
            end
            if ((abt_pend_reg[gb] || (sel_con && !set_req)) && !set_req) begin
              req_reg[gb] <= 1'b0;
              abt_reg[gb] <= 1'b1;
              abt_pend_reg[gb] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // frame storage writes; reserved bits are masked on the way in
  integer k;
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (k = 0; k < `CANTX_NUM_BUF; k = k + 1) begin
        idh_reg[k] <= `CANTX_RESET_BYTE;
        idl_reg[k] <= `CANTX_RESET_BYTE;
        eidh_reg[k] <= `CANTX_RESET_BYTE;
        eidl_reg[k] <= `CANTX_RESET_BYTE;
        len_reg[k] <= `CANTX_RESET_BYTE;
      end
      for (k = 0; k < 24; k = k + 1) begin
        pay_reg[k] <= `CANTX_RESET_BYTE;
      end
    end else if (wr_go && addr_hi_ok &&
                 region != `CANTX_REGION_COMMON) begin
      if (is_payload(word)) begin
        pay_reg[region * 8 + word[2:0]] <= i_pwdata[7:0];
      end else begin
        case (word)
          `CANTX_W_IDENT_HIGH: idh_reg[region] <= i_pwdata[7:0];
          `CANTX_W_IDENT_LOW: idl_reg[region] <= i_pwdata[7:0] & 8'hEB;
          `CANTX_W_EXT_HIGH: eidh_reg[region] <= i_pwdata[7:0];
          `CANTX_W_EXT_LOW: eidl_reg[region] <= i_pwdata[7:0];
          `CANTX_W_LENGTH: len_reg[region] <= i_pwdata[7:0] & 8'h4F;
          // control words are owned by the per-buffer flag logic
          default: ;
        endcase
      end
    end
  end

  // pick the pending buffer with the highest priority
  reg [1:0] pick;
  reg pick_ok;
  integer b;
  // own loop index so the storage process stays the only driver of k
  integer j;
  always @* begin
    pick = 2'd0;
    pick_ok = 1'b0;
    for (b = 0; b < `CANTX_NUM_BUF; b = b + 1) begin
      // strict compare keeps the lowest index among equals
      if (req_reg[b] && beats(pri_reg[b*2 +: 2], pri_reg[pick*2 +: 2],
                              pick_ok)) begin
        pick = b[1:0];
        pick_ok = 1'b1;
      end
    end
  end

  // launch sequencer; frame fields are captured at launch so software
  // may rewrite a buffer while its frame is on the wire
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      cur_reg <= 2'd0;
      o_tx_start <= 1'b0;
      o_tx_busy <= 1'b0;
      o_tx_ident <= 29'h0000_0000;
      o_tx_extended <= 1'b0;
      o_tx_remote <= 1'b0;
      o_tx_length <= 4'h0;
      o_tx_payload <= 64'h0000_0000_0000_0000;
    end else begin
      o_tx_start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (pick_ok && !o_bus_off_flag) begin
            state_reg <= ST_SEND;
            cur_reg <= pick;
            o_tx_start <= 1'b1;
            o_tx_busy <= 1'b1;
            o_tx_extended <= idl_reg[pick][`CANTX_IDL_EXT_SEL];
            if (idl_reg[pick][`CANTX_IDL_EXT_SEL]) begin
              o_tx_ident <= {idh_reg[pick], idl_reg[pick][7:5],
                             idl_reg[pick][1:0], eidh_reg[pick],
                             eidl_reg[pick]};
            end else begin
              // extension bytes ignored, priority never enters the id
              o_tx_ident <= {18'h00000, idh_reg[pick],
                             idl_reg[pick][7:5]};
            end
            o_tx_remote <= len_reg[pick][`CANTX_LEN_REMOTE];
            // reserved codes pass through; engine sends eight bytes
            o_tx_length <= len_reg[pick][3:0];
            for (j = 0; j < `CANTX_NUM_BYTES; j = j + 1) begin
              o_tx_payload[j*8 +: 8] <= pay_reg[pick * 8 + j];
            end
          end
        end
        ST_SEND: begin
          if (cur_done || cur_fail) begin
            state_reg <= ST_IDLE;
            o_tx_busy <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          o_tx_busy <= 1'b0;
        end
      endcase
    end
  end

  // error count: +8 per bus error, -1 per good frame, saturating
  always @* begin
    tec_next = tec_reg;
    if ((state_reg == ST_SEND) && i_tx_bus_err && !i_tx_done) begin
      if (tec_reg > (`CANTX_TEC_MAX - `CANTX_TEC_ERR_STEP)) begin
        tec_next = `CANTX_TEC_MAX;
      end else begin
        tec_next = tec_reg + `CANTX_TEC_ERR_STEP;
      end
    end else if (cur_done && tec_reg != 9'h000) begin
      tec_next = tec_reg - 9'h001;
    end
    if (i_recessive_run && run_cnt_reg == `CANTX_RECOVERY_RUNS) begin
      tec_next = 9'h000;
    end
  end

  // counter, recovery runs and the flags derived from the count
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      tec_reg <= 9'h000;
      run_cnt_reg <= 7'h00;
      o_bus_off_flag <= 1'b0;
      o_send_passive_flag <= 1'b0;
    end else begin
      tec_reg <= tec_next;
      if (i_recessive_run) begin
        run_cnt_reg <= run_cnt_reg + 7'h01;
      end
      o_bus_off_flag <= tec_next > `CANTX_TEC_BUS_OFF;
      o_send_passive_flag <= tec_next > `CANTX_TEC_PASSIVE;
    end
  end

endmodule

// file: tb/cantx_asserts.sv
// checker on the transmit buffer set ports
`timescale 1ns/10ps
module cantx_asserts (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_tx_done,
  input wire i_tx_arb_lost,
  input wire i_tx_bus_err,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_tx_start,
  input wire o_tx_busy,
  input wire [28:0] o_tx_ident,
  input wire o_tx_extended,
  input wire o_bus_off_flag,
  input wire o_send_passive_flag
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // first access cycle, then an engine result on a busy frame
  sequence s_access;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_result;
    o_tx_busy && (i_tx_done || i_tx_arb_lost || i_tx_bus_err);
  endsequence
  a_pready_next: assert property (s_access |=> o_pready)
    else $error("pready late");
  a_pready_single: assert property (o_pready |=> !o_pready)
    else $error("pready too long");
  a_slverr_ready: assert property (o_pslverr |-> o_pready)
    else $error("slverr alone");
  a_start_pulse: assert property (o_tx_start |-> o_tx_busy ##1 !o_tx_start)
    else $error("start pulse bad");
  a_result_gap: assert property (s_result |=> !o_tx_busy && !o_tx_start)
    else $error("busy after result");
  a_fields_hold: assert property (o_tx_busy && !o_tx_start |->
    $stable(o_tx_ident) && $stable(o_tx_extended))
    else $error("frame fields moved");
  a_standard_id: assert property (o_tx_start && !o_tx_extended |->
    o_tx_ident[28:11] == 18'h0)
    else $error("standard id has high bits");
  a_busoff_blocks: assert property (o_bus_off_flag |-> !o_tx_start)
    else $error("start while bus off");
  a_flag_order: assert property (o_bus_off_flag |-> o_send_passive_flag)
    else $error("bus off without passive");
endmodule

bind cantx_buffer_set cantx_asserts u_chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_tx_done(i_tx_done), .i_tx_arb_lost(i_tx_arb_lost),
  .i_tx_bus_err(i_tx_bus_err), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_tx_start(o_tx_start), .o_tx_busy(o_tx_busy), .o_tx_ident(o_tx_ident),
  .o_tx_extended(o_tx_extended), .o_bus_off_flag(o_bus_off_flag),
  .o_send_passive_flag(o_send_passive_flag));

// file: tb/cantx_engine_model.sv
// frame engine stand-in: one result pulse per started frame in modes 0 to 2, none in mode 3
`timescale 1ns/10ps
module cantx_engine_model (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_tx_start,
  input wire [1:0] i_mode,
  input wire [7:0] i_delay,
  output reg o_tx_done,
  output reg o_tx_arb_lost,
  output reg o_tx_bus_err
);
  reg pend_reg;
  reg [7:0] wait_reg;
  // mode is read at the result edge so the bench may change it mid-frame
  always @(posedge i_clock) begin
    o_tx_done <= 1'b0;
    o_tx_arb_lost <= 1'b0;
    o_tx_bus_err <= 1'b0;
    if (i_sys_rst) begin
      pend_reg <= 1'b0;
      wait_reg <= 8'h00;
    end else if (i_tx_start) begin
      pend_reg <= 1'b1;
      wait_reg <= i_delay;
    end else if (pend_reg && wait_reg != 8'h00) begin
      wait_reg <= wait_reg - 8'h01;
    end else if (pend_reg) begin
      pend_reg <= 1'b0;
      o_tx_done <= (i_mode == 2'h0);
      o_tx_arb_lost <= (i_mode == 2'h1);
      o_tx_bus_err <= (i_mode == 2'h2);
    end
  end
endmodule

// file: tb/cantx_buffer_set_bench.sv
// register-level bench for the transmit buffer set
`timescale 1ns/10ps
module cantx_buffer_set_bench;
  reg i_clock, i_sys_rst, psel, pen, pwr, run;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [1:0] mode;
  reg [7:0] delay;
  reg er;
  wire [31:0] prdata;
  wire pready, pslverr, done, arb, berr, start, busy, ext, rtr, boff, pasv;
  wire [28:0] ident;
  wire [3:0] len;
  wire [63:0] pay;
  integer err_total, check_count, cyc, n, m;

  cantx_buffer_set i_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_tx_done(done), .i_tx_arb_lost(arb),
    .i_tx_bus_err(berr), .i_recessive_run(run), .o_tx_start(start),
    .o_tx_busy(busy), .o_tx_ident(ident), .o_tx_extended(ext),
    .o_tx_remote(rtr), .o_tx_length(len), .o_tx_payload(pay),
    .o_bus_off_flag(boff), .o_send_passive_flag(pasv));
  cantx_engine_model i_eng (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_tx_start(start), .i_mode(mode), .i_delay(delay), .o_tx_done(done),
    .o_tx_arb_lost(arb), .o_tx_bus_err(berr));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // a hang counts as a mismatch; the full run needs about 1600 cycles
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      test_done;
    end
  end

  task automatic chk(input string nm, input [63:0] seen, input [63:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function [11:0] ra(input integer b, input integer w);
    ra = 12'(b * 64 + w * 4);
  endfunction

  // request held from setup until pready is sampled high
  task automatic xfer(input bit wr, input [11:0] a, input [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    while (pready !== 1'b1) @(posedge i_clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input [11:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input [11:0] a, input [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic wait_start(input [7:0] idh);
    @(posedge i_clock);
    while (start !== 1'b1) @(posedge i_clock);
    chk("started id", ident[10:3], idh);
  endtask

  task automatic wait_idle;
    while (busy !== 1'b0) @(posedge i_clock);
  endtask

  // two buffers join a busy one; they must leave in the given order
  task automatic order(input [1:0] p1, p2, input [7:0] f, s);
    wr(ra(0, 0), 32'h08);
    wait_start(8'h10);
    wr(ra(1, 0), {28'h0, 2'b10, p1});
    wr(ra(2, 0), {28'h0, 2'b10, p2});
    wait_start(f);
    wait_start(s);
    wait_idle;
  endtask

  initial begin
    {i_sys_rst, psel, pen, pwr, run} = 5'b10000;
    {paddr, pwdata, mode, delay} = 0;
    {err_total, check_count, cyc} = 0;
    repeat (12) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    for (n = 0; n < 3; n++) rdchk("control", ra(n, 0), 32'h0);
    rdchk("count", 12'hC0, 32'h0);
    xfer(1'b0, 12'h018, 32'h0);
    chk("slverr", {er, rd}, 33'h100000000);
    wr(ra(1, 2), 32'hFF);
    rdchk("id low", ra(1, 2), 32'hEB);
    wr(ra(1, 5), 32'hFF);
    rdchk("length", ra(1, 5), 32'h4F);
    wr(ra(2, 0), 32'hF7);
    rdchk("control", ra(2, 0), 32'h03);
    for (n = 0; n < 3; n++)
      for (m = 0; m < 8; m++) wr(ra(n, 8 + m), 32'hA0 + n * 16 + m);
    for (n = 0; n < 3; n++)
      for (m = 0; m < 8; m++)
        rdchk("payload", ra(n, 8 + m), 32'hA0 + n * 16 + m);
    // standard frame with remote request; extension bytes must not show
    delay <= 8'h03;
    wr(ra(0, 1), 32'hA5);
    wr(ra(0, 2), 32'hE3);
    wr(ra(0, 3), 32'h55);
    wr(ra(0, 4), 32'h66);
    wr(ra(0, 5), 32'h48);
    wr(ra(0, 0), 32'h08);
    wait_start(8'hA5);
    chk("std id", ident, {18'h0, 8'hA5, 3'h7});
    chk("fmt rtr len", {ext, rtr, len}, 6'h18);
    chk("payload", pay, 64'hA7A6A5A4A3A2A1A0);
    wait_idle;
    rdchk("done ctl", ra(0, 0), 32'h0);
    // extended frame at top priority
    wr(ra(1, 1), 32'h9C);
    wr(ra(1, 2), 32'hAA);
    wr(ra(1, 3), 32'h3C);
    wr(ra(1, 4), 32'h5A);
    wr(ra(1, 5), 32'h03);
    wr(ra(1, 0), 32'h0B);
    wait_start(8'h8B);
    chk("ext id", ident, {8'h9C, 3'h5, 2'h2, 8'h3C, 8'h5A});
    chk("fmt rtr len", {ext, rtr, len}, 6'h23);
    wait_idle;
    rdchk("done ctl", ra(1, 0), 32'h03);
    for (n = 0; n < 3; n++) begin
      wr(ra(n, 1), 32'h10 * (n + 1));
      wr(ra(n, 2), 32'h0);
    end
    delay <= 8'd60;
    order(2'd0, 2'd3, 8'h30, 8'h20);
    order(2'd1, 2'd0, 8'h20, 8'h30);
    order(2'd2, 2'd2, 8'h20, 8'h30);
    // abort of a waiting buffer, then a fresh request
    wr(ra(0, 0), 32'h08);
    wait_start(8'h10);
    wr(ra(1, 0), 32'h08);
    wr(ra(1, 0), 32'h00);
    rdchk("aborted", ra(1, 0), 32'h40);
    wr(ra(1, 0), 32'h08);
    rdchk("requeued", ra(1, 0), 32'h08);
    wait_start(8'h20);
    wait_idle;
    // lost arbitration, bus error, then success on retries
    {mode, delay} <= {2'd1, 8'd2};
    wr(ra(0, 0), 32'h08);
    wait_start(8'h10);
    wait_idle;
    mode <= 2'd2;
    wait_start(8'h10);
    wait_idle;
    mode <= 2'd0;
    wait_start(8'h10);
    wait_idle;
    rdchk("flags", ra(0, 0), 32'h30);
    rdchk("count", 12'hC0, 32'h07);
    // abort asked while the frame is on the wire lands on the lost try
    {mode, delay} <= {2'd1, 8'd30};
    wr(ra(0, 0), 32'h08);
    wait_start(8'h10);
    wr(ra(0, 0), 32'h00);
    rdchk("pending", ra(0, 0), 32'h08);
    wait_idle;
    rdchk("wire abort", ra(0, 0), 32'h60);
    // errors until bus off, then recovery by recessive runs
    {mode, delay} <= {2'd2, 8'd2};
    wr(ra(0, 0), 32'h08);
    while (boff !== 1'b1) @(posedge i_clock);
    mode <= 2'd0;
    rdchk("count", 12'hC0, 32'hFF);
    rdchk("status", 12'hC4, 32'h30);
    chk("passive", pasv, 1'b1);
    chk("busy", busy, 1'b0);
    for (n = 0; n < 128; n++) begin
      if (n == 127) rdchk("count", 12'hC0, 32'hFF);
      run <= 1'b1;
      @(posedge i_clock);
      run <= 1'b0;
      @(posedge i_clock);
    end
    wait_start(8'h10);
    wait_idle;
    rdchk("count", 12'hC0, 32'h0);
    rdchk("status", 12'hC4, 32'h0);
    chk("passive", pasv, 1'b0);
    chk("bus off", boff, 1'b0);
    test_done;
  end
endmodule
